// ---- verilog/wake_power_cfg.svh ----
// Register map, field positions, reset values and timing constants of the wake power block.
// Summary of operation
// RL1 - Enabled wake events switch the supply on.
// RL2 - Panel off, software off, power fail switch off.
// RL3 - Panel switch debounced on 32.768 kHz ticks.
// RL4 - Four second press forces supply off at once.
// RL5 - Power fail flag bit 7, write one clears.
// RL6 - Bit 6 clears off-save timer, self-clearing.
// RL7 - Bit 5 software off, immediate, self-clearing.
// RL8 - Bit 4 mirrors fail flag, blocks non-panel wakes.
// RL9 - Bit 3 clears management interrupt, self-clearing.
// RL10 - Bit 2 selects level or edge interrupt.
// RL11 - Ring mode: falling edge or 11Hz train.
// RL12 - Bit 0 halts the off delay timer.
// RL13 - Enable bits let falling edges wake supply.
// RL14 - Alarm B enable wakes supply on alarm.
// RL15 - Status bit 7 shows phone ring level.
// RL16 - Bit 5 shows panel off seen, writable.
// RL17 - Bit 4 set at delay expiry, read clears.
// RL18 - Ring edges set bits 3..1, read clears.
// RL19 - Alarm B sets bit 0, read clears.
// RL20 - Clock and wake edges set bits 3..0.
// RL21 - Bits 7:6 select 0, 5, 13, 21 s.
// RL22 - Bit 5 sets interrupt polarity, tristate idle.
// RL23 - Supply stays on until an off event.
// RL24 - Wake inputs synchronised before edge detection.
`ifndef WAKE_POWER_CFG_SVH
`define WAKE_POWER_CFG_SVH

`define ADDR_CTRL        8'h49
`define ADDR_ENABLE      8'h4a
`define ADDR_STAT_A      8'h4b
`define ADDR_STAT_B      8'h4c

`define CTRL_PF          7
`define CTRL_CLEAR_OFF_SAVE_TIMER      6
`define CTRL_SOFTOFF     5
`define CTRL_BLOCK       4
`define CTRL_CLRIRQ      3
`define CTRL_LEVEL       2
`define CTRL_RINGMODE    1
`define CTRL_HALT        0

`define STA_RINGLVL      7
`define STA_PANELOFF     5
`define STA_EXPIRED      4
`define STB_POLARITY     5

`define RESET_BYTE       8'h00
`define CLK_HZ           125000000
`define RTC_HZ           32768
`define TICK_DIV         (`CLK_HZ / `RTC_HZ)
`define DEBOUNCE_TICKS   16'h0200
`define OVERRIDE_SEC     4
`define RING_WINDOW_MS   200
`define RING_MAX_GAP_MS  90
`define RING_PULSES      2
`define DELAY_SEC_1      5
`define DELAY_SEC_2      13
`define DELAY_SEC_3      21

`endif

// ---- verilog/wake_power_pkg.sv ----
// Types shared by the wake power block.
package wake_power_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic mouse_clk;
        logic kbd_clk;
        logic ring_b;
        logic ring_a;
        logic phone_ring;
        logic wake2;
        logic wake1;
    } wake_pins_s;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_ON,
        PWR_OFF_DELAY
    } pwr_state_e;
endpackage

// ---- verilog/wake_power_control.sv ----
// Always-on power switching and wake event logic with its four control registers.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "wake_power_cfg.svh"
module wake_power_control #(
    parameter int unsigned TICK_DIV       = `TICK_DIV,
    parameter int unsigned TICKS_PER_SEC  = `RTC_HZ,
    parameter int unsigned DEBOUNCE_TICKS = `DEBOUNCE_TICKS
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire wake_power_pkg::reg_req_s req,
    output logic [7:0]                    rdata,
    input  wire wake_power_pkg::wake_pins_s pins,
    input  wire logic                     panel_switch_n,
    input  wire logic                     power_fail,
    input  wire logic                     alarm_b_hit,
    output logic                          supply_on_ctl,
    output logic                          mgmt_irq_out,
    output logic                          mgmt_irq_oe
);
    import wake_power_pkg::*;

    localparam int unsigned SECW = 32;
    localparam logic [SECW-1:0] OVR_TICKS  = SECW'(`OVERRIDE_SEC * TICKS_PER_SEC);
    localparam logic [SECW-1:0] RING_WIN   = SECW'(`RING_WINDOW_MS * TICKS_PER_SEC / 1000);
    localparam logic [SECW-1:0] RING_GAP   = SECW'(`RING_MAX_GAP_MS * TICKS_PER_SEC / 1000);
    localparam logic [SECW-1:0] DEB_TICKS  = SECW'(DEBOUNCE_TICKS);

    typedef struct packed {
        logic [15:0]     div;
        logic            tick;
        logic [6:0]      sync1;
        logic [6:0]      sync2;
        logic [6:0]      prev;
        logic            psw1;
        logic            psw2;
        logic            psw_stable;
        logic [SECW-1:0] deb_cnt;
        logic [SECW-1:0] hold_cnt;
        logic            override_done;
        logic            pf1;
        logic            pf2;
        logic            pf_prev;
        logic            alarm_prev;
        logic [SECW-1:0] ring_win;
        logic [SECW-1:0] ring_gap;
        logic [3:0]      ring_pulses;
        logic            ring_active;
        logic [7:0]      ctrl;
        logic [7:0]      enable;
        logic [7:0]      stat_a;
        logic [7:0]      stat_b;
        pwr_state_e      pstate;
        logic [SECW-1:0] delay_cnt;
        logic            irq;
        logic            supply;
        logic            irq_pin;
        logic            irq_oe;
        logic [7:0]      rdata;
    } state_s;

    state_s cur;
    state_s next_cur;

    function automatic logic [SECW-1:0] delay_of(input logic [1:0] sel);
        case (sel)
            2'b01:   delay_of = SECW'(`DELAY_SEC_1 * TICKS_PER_SEC);
            2'b10:   delay_of = SECW'(`DELAY_SEC_2 * TICKS_PER_SEC);
            2'b11:   delay_of = SECW'(`DELAY_SEC_3 * TICKS_PER_SEC);
            default: delay_of = '0;
        endcase
    endfunction

    always_comb begin
        logic [6:0] falls;
        logic       press;
        logic       ring_event;
        logic       alarm_ev;
        logic       pf_rise;
        logic       wake_any;
        logic       off_now;
        logic       expired;
        logic       irq_event;
        logic       rd_a;
        logic       rd_b;
        falls      = '0;
        press      = 1'b0;
        ring_event = 1'b0;
        alarm_ev   = 1'b0;
        pf_rise    = 1'b0;
        wake_any   = 1'b0;
        off_now    = 1'b0;
        expired    = 1'b0;
        irq_event  = 1'b0;
        rd_a       = req.rd && req.addr == `ADDR_STAT_A;
        rd_b       = req.rd && req.addr == `ADDR_STAT_B;
        next_cur   = cur;

        // The wake pins, panel switch and timers advance on a slow tick standing in for the RTC oscillator.
        next_cur.tick = 1'b0;
        if (cur.div >= 16'(TICK_DIV - 1)) begin
            next_cur.div  = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.div = cur.div + 16'h0001;
        end

        // Power fail and alarm are sampled every cycle so a short event is never missed.
        next_cur.pf1        = power_fail;
        next_cur.pf2        = cur.pf1;
        next_cur.pf_prev    = cur.pf2;
        pf_rise             = cur.pf2 && !cur.pf_prev;
        next_cur.alarm_prev = alarm_b_hit;
        alarm_ev            = alarm_b_hit && !cur.alarm_prev;

        if (cur.tick) begin
            next_cur.sync1 = pins; // see RL24
            next_cur.sync2 = cur.sync1;
            next_cur.prev  = cur.sync2;
            falls          = cur.prev & ~cur.sync2;
            next_cur.psw1  = !panel_switch_n;
            next_cur.psw2  = cur.psw1;
            // A level change must hold for the whole debounce window to count.
            if (cur.psw2 != cur.psw_stable) begin // see RL3
                if (cur.deb_cnt >= DEB_TICKS) begin
                    next_cur.psw_stable = cur.psw2;
                    next_cur.deb_cnt    = '0;
                    press               = cur.psw2;
                end else begin
                    next_cur.deb_cnt = cur.deb_cnt + 1'b1;
                end
            end else begin
                next_cur.deb_cnt = '0;
            end
            if (cur.psw_stable && !cur.override_done) begin
                next_cur.hold_cnt = cur.hold_cnt + 1'b1;
            end else if (!cur.psw_stable) begin
                next_cur.hold_cnt      = '0;
                next_cur.override_done = 1'b0;
            end
            // Ring train: pulses no further apart than the gap, lasting the full window.
            if (cur.ctrl[`CTRL_RINGMODE]) begin // see RL11
                ring_event           = falls[2];
                next_cur.ring_active = 1'b0;
            end else if (falls[2]) begin
                next_cur.ring_gap = '0;
                if (!cur.ring_active) begin
                    next_cur.ring_active = 1'b1;
                    next_cur.ring_win    = '0;
                    next_cur.ring_pulses = 4'h1;
                end else if (cur.ring_pulses != 4'hf) begin
                    next_cur.ring_pulses = cur.ring_pulses + 4'h1;
                end
            end else if (cur.ring_active) begin
                next_cur.ring_gap = cur.ring_gap + 1'b1;
                next_cur.ring_win = cur.ring_win + 1'b1;
                if (cur.ring_gap >= RING_GAP) begin
                    next_cur.ring_active = 1'b0;
                end else if (cur.ring_win >= RING_WIN &&
                             cur.ring_pulses >= 4'(`RING_PULSES)) begin
                    ring_event           = 1'b1;
                    next_cur.ring_active = 1'b0;
                end
            end
        end

        // Register writes; self-clearing command bits are never stored.
        if (req.wr) begin
            case (req.addr)
                `ADDR_CTRL: begin
                    next_cur.ctrl[2:0] = req.wdata[2:0];
                    if (req.wdata[`CTRL_PF]) begin
                        next_cur.ctrl[`CTRL_PF] = 1'b0; // see RL5
                    end
                end
                `ADDR_ENABLE: next_cur.enable = req.wdata;
                `ADDR_STAT_A: next_cur.stat_a[`STA_PANELOFF] = req.wdata[`STA_PANELOFF]; // see RL16
                `ADDR_STAT_B: next_cur.stat_b[7:5] = req.wdata[7:5]; // see RL21
                default: ;
            endcase
        end
        if (rd_a) begin
            next_cur.stat_a[`STA_EXPIRED] = 1'b0; // see RL17
            next_cur.stat_a[3:0]          = '0;   // see RL18
        end
        if (rd_b) begin
            next_cur.stat_b[3:0] = '0; // see RL20
        end

        // Hardware sets come after the clears so a simultaneous event wins.
        if (pf_rise) begin
            next_cur.ctrl[`CTRL_PF] = 1'b1; // see RL5
        end
        next_cur.ctrl[`CTRL_BLOCK] = next_cur.ctrl[`CTRL_PF]; // see RL8
        next_cur.ctrl[7:3]         = {next_cur.ctrl[7], 2'b00, next_cur.ctrl[`CTRL_BLOCK], 1'b0};
        if (falls[4]) next_cur.stat_a[3] = 1'b1; // see RL18
        if (falls[3]) next_cur.stat_a[2] = 1'b1;
        if (ring_event) next_cur.stat_a[1] = 1'b1;
        if (alarm_ev) next_cur.stat_a[0] = 1'b1; // see RL19
        if (falls[6]) next_cur.stat_b[3] = 1'b1; // see RL20
        if (falls[5]) next_cur.stat_b[2] = 1'b1;
        if (falls[1]) next_cur.stat_b[1] = 1'b1;
        if (falls[0]) next_cur.stat_b[0] = 1'b1;
        next_cur.stat_b[4] = 1'b0;
        next_cur.stat_a[6] = 1'b0;
        next_cur.stat_a[`STA_RINGLVL] = cur.sync2[2]; // see RL15

        wake_any = (falls[6] && cur.enable[7]) || (falls[5] && cur.enable[6]) // see RL13
                || (falls[4] && cur.enable[5]) || (falls[3] && cur.enable[4])
                || (ring_event && cur.enable[3]) || (falls[1] && cur.enable[2])
                || (falls[0] && cur.enable[1])
                || (alarm_ev && cur.enable[0]); // see RL14
        if (cur.ctrl[`CTRL_BLOCK]) begin
            wake_any = 1'b0; // see RL8
        end

        // Power state: on events, orderly off with delay, and forced off paths.
        off_now = (req.wr && req.addr == `ADDR_CTRL && req.wdata[`CTRL_SOFTOFF]) // see RL7
               || pf_rise; // see RL2
        if (cur.tick && cur.psw_stable && !cur.override_done && cur.hold_cnt >= OVR_TICKS) begin
            off_now                = 1'b1; // see RL4
            next_cur.override_done = 1'b1;
        end
        case (cur.pstate)
            PWR_OFF: begin
                if (press || wake_any) begin // see RL1
                    next_cur.pstate = PWR_ON;
                    irq_event       = 1'b1;
                end
            end
            PWR_ON: begin
                // The panel switch is a push button, so a second debounced press is the off event.
                if (press && !off_now) begin // see RL2
                    next_cur.stat_a[`STA_PANELOFF] = 1'b1; // see RL16
                    next_cur.delay_cnt = delay_of(cur.stat_b[7:6]); // see RL21
                    next_cur.pstate    = PWR_OFF_DELAY;
                    irq_event          = 1'b1;
                end
            end
            PWR_OFF_DELAY: begin
                if (req.wr && req.addr == `ADDR_CTRL && req.wdata[`CTRL_CLEAR_OFF_SAVE_TIMER]) begin
                    next_cur.delay_cnt = '0; // see RL6
                    next_cur.pstate    = PWR_ON;
                end else if (cur.delay_cnt == '0) begin
                    expired = 1'b1;
                end else if (cur.tick && !cur.ctrl[`CTRL_HALT]) begin // see RL12
                    next_cur.delay_cnt = cur.delay_cnt - 1'b1;
                end
                if (expired) begin
                    next_cur.stat_a[`STA_EXPIRED] = 1'b1; // see RL17
                    next_cur.pstate = PWR_OFF;
                end
            end
            default: next_cur.pstate = PWR_OFF;
        endcase
        if (off_now) begin
            next_cur.pstate = PWR_OFF; // see RL23
        end
        next_cur.supply = next_cur.pstate != PWR_OFF;

        // Interrupt: level mode holds until cleared, edge mode is one tick long.
        if (irq_event) begin
            next_cur.irq = 1'b1;
        end else if (req.wr && req.addr == `ADDR_CTRL && req.wdata[`CTRL_CLRIRQ]) begin
            next_cur.irq = 1'b0; // see RL9
        end else if (!cur.ctrl[`CTRL_LEVEL] && cur.tick) begin
            next_cur.irq = 1'b0; // see RL10
        end
        next_cur.irq_oe  = next_cur.irq; // see RL22
        next_cur.irq_pin = next_cur.irq ^ next_cur.stat_b[`STB_POLARITY];

        next_cur.rdata = `RESET_BYTE;
        if (req.rd) begin
            case (req.addr)
                `ADDR_CTRL:   next_cur.rdata = cur.ctrl;
                `ADDR_ENABLE: next_cur.rdata = cur.enable;
                `ADDR_STAT_A: next_cur.rdata = cur.stat_a;
                `ADDR_STAT_B: next_cur.rdata = cur.stat_b;
                default:      next_cur.rdata = `RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur        <= '0;
            cur.pstate <= PWR_OFF;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata         = cur.rdata;
    assign supply_on_ctl = cur.supply;
    assign mgmt_irq_out  = cur.irq_pin;
    assign mgmt_irq_oe   = cur.irq_oe;
endmodule

// ---- bench/wake_power_sva.sv ----
// Port checker for the wake power block.
`timescale 1ns/1ps
module wake_power_sva #(
    parameter int unsigned TICK_DIV       = 2,
    parameter int unsigned TICKS_PER_SEC  = 16,
    parameter int unsigned DEBOUNCE_TICKS = 2
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire wake_power_pkg::reg_req_s   req,
    input wire logic [7:0]                 rdata,
    input wire wake_power_pkg::wake_pins_s pins,
    input wire logic                       panel_switch_n,
    input wire logic                       power_fail,
    input wire logic                       alarm_b_hit,
    input wire logic                       supply_on_ctl,
    input wire logic                       mgmt_irq_out,
    input wire logic                       mgmt_irq_oe
);
    import wake_power_pkg::*;
    // Slack covers the debounce and synchroniser lag ahead of the hold count.
    localparam int unsigned OVR = 4 * TICK_DIV * TICKS_PER_SEC + 8 * TICK_DIV * DEBOUNCE_TICKS;
    logic        pol;
    logic        lvl;
    logic        ring_q;
    logic [4:0]  ring_cnt;
    int unsigned hold_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            pol      <= 1'b0;
            lvl      <= 1'b0;
            ring_q   <= 1'b0;
            ring_cnt <= 5'h00;
            hold_cnt <= 0;
        end else begin
            if (req.wr && req.addr == 8'h4c) pol <= req.wdata[5];
            if (req.wr && req.addr == 8'h49) lvl <= req.wdata[2];
            ring_q   <= pins.phone_ring;
            ring_cnt <= (pins.phone_ring != ring_q) ? 5'h00 : ring_cnt + 5'(ring_cnt != 5'h1f);
            hold_cnt <= panel_switch_n ? 0 : hold_cnt + 32'(hold_cnt < OVR);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_soft_off: assert property (
        req.wr && req.addr == 8'h49 && req.wdata[5] |=> !supply_on_ctl)
        else $error("supply still on after software off");
    chk_fail_off: assert property (
        $rose(power_fail) |-> ##[1:16] !supply_on_ctl)
        else $error("supply still on after power fail");
    chk_irq_pol: assert property (
        mgmt_irq_oe |-> mgmt_irq_out == !pol)
        else $error("interrupt level does not follow polarity");
    chk_irq_clear: assert property (
        req.wr && req.addr == 8'h49 && req.wdata[3] |=> !mgmt_irq_oe)
        else $error("interrupt not cleared by command");
    chk_edge_drop: assert property (
        $rose(mgmt_irq_oe) && !lvl |-> ##[1:4] !mgmt_irq_oe)
        else $error("edge interrupt did not drop");
    chk_level_hold: assert property (
        $rose(mgmt_irq_oe) && lvl |=> mgmt_irq_oe [*8])
        else $error("level interrupt dropped early");
    chk_ring_level: assert property (
        req.rd && req.addr == 8'h4b && ring_cnt == 5'h1f |=> rdata[7] == ring_q)
        else $error("ring level bit wrong");
    chk_fail_mirror: assert property (
        req.rd && req.addr == 8'h49 |=> rdata[4] == rdata[7])
        else $error("block bit does not mirror fail flag");
    chk_cmd_selfclr: assert property (
        req.rd && req.addr == 8'h49 |=> rdata[6:5] == 2'b00 && !rdata[3])
        else $error("command bit reads back set");
    chk_override: assert property (
        hold_cnt == OVR |-> !supply_on_ctl)
        else $error("long press did not force supply off");
endmodule
bind wake_power_control wake_power_sva #(
    .TICK_DIV(TICK_DIV), .TICKS_PER_SEC(TICKS_PER_SEC), .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
) u_sva (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .pins(pins),
    .panel_switch_n(panel_switch_n), .power_fail(power_fail), .alarm_b_hit(alarm_b_hit),
    .supply_on_ctl(supply_on_ctl), .mgmt_irq_out(mgmt_irq_out), .mgmt_irq_oe(mgmt_irq_oe)
);

// ---- bench/wake_partner.sv ----
// Wake sources, panel switch, alarm and power sense standing outside the block.
`timescale 1ns/1ps
module wake_partner (
    input  wire logic                 clk,
    output wake_power_pkg::wake_pins_s pins,
    output logic                      panel_switch_n,
    output logic                      power_fail,
    output logic                      alarm_b_hit
);
    import wake_power_pkg::*;
    // Lines rest high as pulled up; a pulse must outlast the synchroniser.
    initial begin
        pins = '1;
        panel_switch_n = 1'b1;
        power_fail = 1'b0;
        alarm_b_hit = 1'b0;
    end
    task automatic fall(input int idx, input int len);
        @(posedge clk);
        case (idx)
            0:       pins.wake1      <= 1'b0;
            1:       pins.wake2      <= 1'b0;
            2:       pins.phone_ring <= 1'b0;
            3:       pins.ring_a     <= 1'b0;
            4:       pins.ring_b     <= 1'b0;
            5:       pins.kbd_clk    <= 1'b0;
            default: pins.mouse_clk  <= 1'b0;
        endcase
        repeat (len) @(posedge clk);
        pins <= '1;
    endtask
    task automatic press(input int len);
        @(posedge clk);
        panel_switch_n <= 1'b0;
        repeat (len) @(posedge clk);
        panel_switch_n <= 1'b1;
        // The switch rests released long enough for the debounce to see the release.
        repeat (24) @(posedge clk);
    endtask
    task automatic restore();
        @(posedge clk);
        power_fail <= 1'b0;
    endtask
    task automatic alarm();
        @(posedge clk);
        alarm_b_hit <= 1'b1;
        repeat (4) @(posedge clk);
        alarm_b_hit <= 1'b0;
    endtask
    task automatic fail();
        @(posedge clk);
        power_fail <= 1'b1;
    endtask
endmodule

// ---- bench/tb_wake_power_control.sv ----
// Self-checking bench for the wake power block.
`timescale 1ns/1ps
module tb_wake_power_control;
    import wake_power_pkg::*;
    logic       clk;
    logic       rst;
    reg_req_s   req;
    logic [7:0] rdata;
    wake_pins_s pins;
    logic       panel_switch_n;
    logic       power_fail;
    logic       alarm_b_hit;
    logic       supply_on_ctl;
    logic       mgmt_irq_out;
    logic       mgmt_irq_oe;
    int         bad_count;
    int         check_count;
    logic [7:0] st_addr [7] = '{8'h4c, 8'h4c, 8'h4b, 8'h4b, 8'h4b, 8'h4c, 8'h4c};
    int         st_bit  [7] = '{0, 1, 1, 2, 3, 2, 3};
    wake_power_control #(.TICK_DIV(2), .TICKS_PER_SEC(16), .DEBOUNCE_TICKS(2)) dut (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .pins(pins),
        .panel_switch_n(panel_switch_n), .power_fail(power_fail), .alarm_b_hit(alarm_b_hit),
        .supply_on_ctl(supply_on_ctl), .mgmt_irq_out(mgmt_irq_out), .mgmt_irq_oe(mgmt_irq_oe));
    wake_partner src (.clk(clk), .pins(pins), .panel_switch_n(panel_switch_n),
        .power_fail(power_fail), .alarm_b_hit(alarm_b_hit));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        $display("counts: %0d checks, %0d mismatches", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 check(rdata, e);
    endtask
    task automatic wait_sup(input logic val, input int lim);
        int n;
        n = 0;
        while (supply_on_ctl !== val && n < lim) begin
            cyc(1);
            n++;
        end
        if (supply_on_ctl !== val) begin
            bad_count++;
            $display("mismatch at %0t: supply wait ran out", $time);
            close_out();
        end
        check({7'h00, supply_on_ctl}, {7'h00, val});
    endtask
    initial begin
        req = '0;
        rst = 1'b1;
        bad_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(20);
        rdchk(8'h49, 8'h00);
        rdchk(8'h4a, 8'h00);
        rdchk(8'h4b, 8'h80);
        rdchk(8'h4c, 8'h00);
        rdchk(8'h50, 8'h00);
        wr(8'h4a, 8'hff);
        rdchk(8'h4a, 8'hff);
        wr(8'h4c, 8'hff);
        rdchk(8'h4c, 8'he0);
        wr(8'h4c, 8'h00);
        wr(8'h49, 8'h02);
        rdchk(8'h49, 8'h02);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h49, 8'h22);
            wait_sup(1'b0, 4);
            src.fall(i, 8);
            wait_sup(1'b1, 40);
            cyc(16);
            rdchk(st_addr[i], (st_addr[i] == 8'h4b ? 8'h80 : 8'h00) | (8'h01 << st_bit[i]));
            rdchk(st_addr[i], (st_addr[i] == 8'h4b ? 8'h80 : 8'h00));
        end
        wr(8'h49, 8'h20);
        repeat (4) begin
            src.fall(2, 2);
            cyc(1);
        end
        wait_sup(1'b1, 40);
        rdchk(8'h4b, 8'h82);
        src.fall(2, 8);
        cyc(20);
        rdchk(8'h4b, 8'h80);
        $display("test wake sources done");
        wr(8'h4a, 8'h00);
        wr(8'h49, 8'h22);
        src.fall(0, 8);
        cyc(30);
        check({7'h00, supply_on_ctl}, 8'h00);
        rdchk(8'h4c, 8'h01);
        wr(8'h4a, 8'h01);
        src.alarm();
        wait_sup(1'b1, 40);
        rdchk(8'h4b, 8'h81);
        $display("test disable and alarm done");
        src.fail();
        wait_sup(1'b0, 20);
        rdchk(8'h49, 8'h92);
        src.restore();
        wr(8'h4a, 8'hff);
        src.fall(0, 8);
        cyc(30);
        check({7'h00, supply_on_ctl}, 8'h00);
        rdchk(8'h4c, 8'h01);
        src.press(20);
        wait_sup(1'b1, 60);
        wr(8'h49, 8'h82);
        rdchk(8'h49, 8'h02);
        src.press(2);
        check({7'h00, supply_on_ctl}, 8'h01);
        $display("test power fail done");
        wr(8'h4c, 8'h40);
        src.press(20);
        cyc(100);
        check({7'h00, supply_on_ctl}, 8'h01);
        rdchk(8'h4b, 8'ha0);
        wait_sup(1'b0, 120);
        rdchk(8'h4b, 8'hb0);
        wr(8'h4b, 8'h00);
        src.press(20);
        wait_sup(1'b1, 60);
        src.press(20);
        wr(8'h49, 8'h42);
        cyc(200);
        check({7'h00, supply_on_ctl}, 8'h01);
        wr(8'h49, 8'h03);
        src.press(20);
        cyc(200);
        check({7'h00, supply_on_ctl}, 8'h01);
        wr(8'h49, 8'h02);
        wait_sup(1'b0, 200);
        $display("test off delay done");
        wr(8'h4c, 8'hc0);
        src.press(20);
        wait_sup(1'b1, 60);
        src.press(180);
        check({7'h00, supply_on_ctl}, 8'h00);
        $display("test override done");
        wr(8'h4c, 8'h20);
        wr(8'h49, 8'h06);
        src.press(20);
        wait_sup(1'b1, 60);
        cyc(20);
        check({7'h00, mgmt_irq_oe}, 8'h01);
        check({7'h00, mgmt_irq_out}, 8'h00);
        wr(8'h49, 8'h0e);
        #1 check({7'h00, mgmt_irq_oe}, 8'h00);
        $display("test interrupt done");
        close_out();
    end
endmodule
